// ===== pcs_map.svh
`ifndef PCS_MAP_SVH
`define PCS_MAP_SVH
// header field positions
`define PCS_HDR_PATH_HI 7
`define PCS_HDR_PATH_LO 6
// path select codes
`define PCS_PATH_ONE 2'h1
`define PCS_PATH_TWO 2'h2
// message class and subtype codes of the header low bits
`define PCS_HDR_CONTROL 6'h2A
`define PCS_HDR_STATUS 6'h0E
`define PCS_HDR_RESPONSE 6'h2E
// control word field positions
`define PCS_DIR_HI 15
`define PCS_DIR_LO 14
`define PCS_MODE_HI 10
`define PCS_MODE_LO 8
// tone command and digit range
`define PCS_TONE_SEND 8'h5A
`define PCS_DIGIT_MIN 8'h10
`define PCS_DIGIT_MAX 8'h1F
// v110 command that sets the extra sync frame count
`define PCS_V110_DELAY 8'h50
// scheme codes
`define PCS_SCH_NONE 8'h00
`define PCS_SCH_V21 8'h41
`define PCS_SCH_V17 8'h82
`define PCS_SCH_V29 8'h92
`define PCS_SCH_V27 8'hA2
`define PCS_SCH_V32 8'h20
`define PCS_SCH_V22 8'h40
`define PCS_SCH_FSK1 8'h51
`define PCS_SCH_V23 8'h61
`define PCS_SCH_FSK2 8'h71
// flag bit positions in third and fourth response bytes
`define PCS_F3_RRET 5
`define PCS_F3_LRET 4
`define PCS_F3_PHASE 2
`define PCS_F3_CONN 1
`define PCS_F3_FIRST 0
`define PCS_F4_TEAR 6
`define PCS_F4_RETRY 5
`define PCS_F4_TMO 4
`define PCS_F4_RRENEG 1
`define PCS_F4_LRENEG 0
// host register offsets
`define PCS_REG_HEADER 4'h0
`define PCS_REG_CTRL 4'h1
`define PCS_REG_PARAM 4'h2
`define PCS_REG_GO 4'h3
`define PCS_REG_STAT 4'h4
`define PCS_REG_RHDR 4'h5
`define PCS_REG_RCTRL 4'h6
`define PCS_REG_RP01 4'h7
`define PCS_REG_RP23 4'h8
`endif

// ===== pcs_pkg.sv
package pcs_pkg;
    // pump path modes
    typedef enum logic [2:0] {
        PCS_MODE_OFF = 3'h0,
        PCS_MODE_FAX = 3'h1,
        PCS_MODE_DATA = 3'h2,
        PCS_MODE_HALF = 3'h3,
        PCS_MODE_V110 = 3'h4,
        PCS_MODE_TONE_RX = 3'h5,
        PCS_MODE_TONE_TX = 3'h6,
        PCS_MODE_BYPASS = 3'h7
    } pcs_mode_t;
    // mailbox message
    typedef struct packed {
        logic [7:0] hdr;
        logic [15:0] ctrl;
        logic [7:0] p0;
        logic [7:0] p1;
        logic [7:0] p2;
        logic [7:0] p3;
    } pcs_msg_t;
endpackage : pcs_pkg

// ===== pcs_if.sv
`timescale 1ns/1ps
interface pcs_if;
    // host to device message
    logic req_valid;
    pcs_pkg::pcs_msg_t req_msg;
    // device to host message
    logic rsp_valid;
    pcs_pkg::pcs_msg_t rsp_msg;
    modport dev (input req_valid, input req_msg, output rsp_valid, output rsp_msg);
    modport host (output req_valid, output req_msg, input rsp_valid, input rsp_msg);
endinterface : pcs_if

// ===== pcs_device.sv
`timescale 1ns/1ps
`include "pcs_map.svh"
// Contract
// - sync after sync_frame_extra plus one good frames
// - host switches to tone-transmit mode first
// - tone_command 5Ah sends one digit
// - digits coded 10h to 1Fh
// - tone transmitter only in tone-transmit mode
// - host enables rate conversion before tones
// - status request control word is zero
// - path_select bits 7:6, 01 or 10; control messages with 00 or 11 act on path one
// - status response: direction, mode, rate, scheme
// - direction upper bit: 0 answer, 1 originate
// - path_mode three-bit codes as listed
// - fax rate codes as listed
// - fax scheme codes, zero means failure
// - datamodem flag bytes three and four
// - datamodem extra rate codes
// - datamodem scheme codes
// - retrain flags set while retrain runs
// - phase flag during retrain or renegotiation
// - connected flag after training completes
// - first-training flag during initial training
// - teardown flag on forced restart
// - retry and timeout flags during training
// - renegotiation flags in byte four
module pcs_device #(
    parameter int FRAME_W = 8
) (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic NRST,
    input wire logic CLK_EN,
    // mailbox
    pcs_if.dev MBOX,
    // pump configuration: per-path mode and direction, shared rate and scheme
    input wire logic [2:0] PATH1_MODE,
    input wire logic [2:0] PATH2_MODE,
    input wire logic PATH1_ORIG,
    input wire logic PATH2_ORIG,
    input wire logic [7:0] RATE_CODE,
    input wire logic [7:0] SCHEME_CODE,
    // pump state events
    input wire logic REMOTE_RETRAIN,
    input wire logic LOCAL_RETRAIN,
    input wire logic REMOTE_RENEG,
    input wire logic LOCAL_RENEG,
    input wire logic TRAINING_DONE,
    input wire logic FIRST_TRAINING,
    input wire logic NO_RATE,
    input wire logic BULK_TIMEOUT,
    input wire logic RETRY_REQ,
    // v110 frame checker
    input wire logic FRAME_OK,
    input wire logic FRAME_BAD,
    // tone transmitter and receive gate
    output logic TONE_STROBE,
    output logic [3:0] TONE_DIGIT,
    output logic TONE_REJECT,
    output logic V110_SYNC,
    output logic RX_DATA_EN
);
    logic [FRAME_W-1:0] sync_frame_extra_q; // extra frames wanted
    logic [FRAME_W:0] good_cnt_q; // consecutive good frames
    logic sync_q; // frame synchronism
    logic tone_strobe_q; // digit pulse
    logic [3:0] tone_digit_q; // digit index
    logic tone_reject_q; // unsupported tone order
    logic rsp_valid_q; // response pulse
    pcs_pkg::pcs_msg_t rsp_q; // response message
    logic [7:0] hdr; // request header
    logic [1:0] psel; // selected path
    pcs_pkg::pcs_mode_t sel_mode; // mode of selected path
    logic sel_orig; // direction of selected path
    logic [7:0] flags3; // third byte flags
    logic [7:0] flags4; // fourth byte flags
    logic ctrl_req; // pump control command this cycle
    logic stat_req; // status request on a legal path

    // header low bits against a message code
    function automatic logic hdr_is(input logic [7:0] h, input logic [5:0] code);
        hdr_is = (h[5:0] == code);
    endfunction : hdr_is

    // upper control byte against a command code
    function automatic logic cmd_is(input logic [15:0] ctrl, input logic [7:0] code);
        cmd_is = (ctrl[15:8] == code);
    endfunction : cmd_is

    // digit code inside the tone range
    function automatic logic digit_ok(input logic [7:0] code);
        digit_ok = (code >= `PCS_DIGIT_MIN) && (code <= `PCS_DIGIT_MAX);
    endfunction : digit_ok

    // only paths one and two exist
    function automatic logic path_ok(input logic [1:0] p);
        path_ok = (p == `PCS_PATH_ONE) || (p == `PCS_PATH_TWO);
    endfunction : path_ok

    // path decode
    always_comb begin
        hdr = MBOX.req_msg.hdr;
        psel = hdr[`PCS_HDR_PATH_HI:`PCS_HDR_PATH_LO];
        sel_mode = pcs_pkg::pcs_mode_t'(psel == `PCS_PATH_TWO ? PATH2_MODE : PATH1_MODE);
        sel_orig = (psel == `PCS_PATH_TWO) ? PATH2_ORIG : PATH1_ORIG;
    end

    // request kinds, shared by the command processes
    always_comb begin
        ctrl_req = MBOX.req_valid && hdr_is(hdr, `PCS_HDR_CONTROL);
        stat_req = MBOX.req_valid && hdr_is(hdr, `PCS_HDR_STATUS) && path_ok(psel);
    end

    // datamodem flag bytes
    always_comb begin
        flags3 = 8'h00;
        flags4 = 8'h00;
        flags3[`PCS_F3_RRET] = REMOTE_RETRAIN;
        flags3[`PCS_F3_LRET] = LOCAL_RETRAIN;
        flags3[`PCS_F3_PHASE] = REMOTE_RETRAIN | LOCAL_RETRAIN | REMOTE_RENEG | LOCAL_RENEG;
        flags3[`PCS_F3_CONN] = TRAINING_DONE & ~FIRST_TRAINING;
        flags3[`PCS_F3_FIRST] = FIRST_TRAINING;
        flags4[`PCS_F4_TEAR] = NO_RATE | BULK_TIMEOUT;
        flags4[`PCS_F4_RETRY] = RETRY_REQ & FIRST_TRAINING;
        flags4[`PCS_F4_TMO] = BULK_TIMEOUT & FIRST_TRAINING;
        flags4[`PCS_F4_RRENEG] = REMOTE_RENEG;
        flags4[`PCS_F4_LRENEG] = LOCAL_RENEG;
    end

    // status response builder
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            rsp_valid_q <= 1'b0;
            rsp_q <= '0;
        end else if (CLK_EN) begin
            rsp_valid_q <= 1'b0;
            // status request: header only, control word ignored
            if (stat_req) begin
                rsp_valid_q <= 1'b1;
                rsp_q <= '0;
                rsp_q.hdr <= {psel, `PCS_HDR_RESPONSE};
                rsp_q.ctrl[`PCS_DIR_HI] <= sel_orig;
                rsp_q.ctrl[`PCS_DIR_LO] <= 1'b0;
                rsp_q.ctrl[`PCS_MODE_HI:`PCS_MODE_LO] <= sel_mode;
                rsp_q.p0 <= RATE_CODE;
                rsp_q.p1 <= SCHEME_CODE;
                if (sel_mode == pcs_pkg::PCS_MODE_DATA) begin
                    rsp_q.p2 <= flags3;
                    rsp_q.p3 <= flags4;
                end
            end
        end
    end

    // tone command handling
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            tone_strobe_q <= 1'b0;
            tone_digit_q <= 4'h0;
            tone_reject_q <= 1'b0;
        end else if (CLK_EN) begin
            tone_strobe_q <= 1'b0;
            tone_reject_q <= 1'b0;
            if (ctrl_req) begin
                if (sel_mode != pcs_pkg::PCS_MODE_TONE_TX) begin
                    tone_reject_q <= 1'b1;
                end else if (cmd_is(MBOX.req_msg.ctrl, `PCS_TONE_SEND) && digit_ok(MBOX.req_msg.p0)) begin
                    tone_strobe_q <= 1'b1;
                    tone_digit_q <= MBOX.req_msg.p0[3:0];
                end else begin
                    tone_reject_q <= 1'b1;
                end
            end
        end
    end

    // v110 sync delay: command 50h sets extra count
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            sync_frame_extra_q <= '0;
        end else if (CLK_EN && ctrl_req && sel_mode == pcs_pkg::PCS_MODE_V110 &&
                     cmd_is(MBOX.req_msg.ctrl, `PCS_V110_DELAY)) begin
            sync_frame_extra_q <= MBOX.req_msg.p0[FRAME_W-1:0];
        end
    end

    // good frame counter and synchronism
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            good_cnt_q <= '0;
            sync_q <= 1'b0;
        end else if (CLK_EN) begin
            if (FRAME_BAD) begin
                good_cnt_q <= '0;
                sync_q <= 1'b0;
            end else if (FRAME_OK && !sync_q) begin
                if (good_cnt_q >= {1'b0, sync_frame_extra_q}) begin
                    sync_q <= 1'b1;
                    good_cnt_q <= '0;
                end else begin
                    good_cnt_q <= good_cnt_q + 1'b1;
                end
            end
        end
    end

    // outputs
    assign MBOX.rsp_valid = rsp_valid_q;
    assign MBOX.rsp_msg = rsp_q;
    assign TONE_STROBE = tone_strobe_q;
    assign TONE_DIGIT = tone_digit_q;
    assign TONE_REJECT = tone_reject_q;
    assign V110_SYNC = sync_q;
    assign RX_DATA_EN = sync_q;
endmodule : pcs_device

// ===== pcs_host.sv
`timescale 1ns/1ps
`include "pcs_map.svh"
module pcs_host (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic NRST,
    input wire logic CLK_EN,
    // software port
    input wire logic [3:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    // configuration knowledge
    input wire logic RATE_CONV_ON,
    // mailbox
    pcs_if.host MBOX
);
    pcs_pkg::pcs_msg_t req_q; // staged request
    logic req_valid_q; // request pulse
    logic busy_q; // status awaiting answer
    pcs_pkg::pcs_msg_t rsp_q; // captured answer
    logic rsp_new_q; // answer pending
    logic refused_q; // last send refused
    logic [31:0] rdata_q; // read data

    // staging and send
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            req_q <= '0;
            req_valid_q <= 1'b0;
            busy_q <= 1'b0;
            refused_q <= 1'b0;
        end else if (CLK_EN) begin
            req_valid_q <= 1'b0;
            if (MBOX.rsp_valid) begin
                busy_q <= 1'b0;
            end
            if (WR) begin
                case (ADDR)
                    `PCS_REG_HEADER: req_q.hdr <= WDATA[7:0];
                    `PCS_REG_CTRL: req_q.ctrl <= WDATA[15:0];
                    `PCS_REG_PARAM: req_q.p0 <= WDATA[7:0];
                    `PCS_REG_GO: begin
                        // tones only with rate conversion on
                        if (req_q.hdr[5:0] == `PCS_HDR_CONTROL &&
                            req_q.ctrl[15:8] == `PCS_TONE_SEND && !RATE_CONV_ON) begin
                            refused_q <= 1'b1;
                        end else begin
                            refused_q <= 1'b0;
                            req_valid_q <= 1'b1;
                            if (req_q.hdr[5:0] == `PCS_HDR_STATUS) begin
                                req_q.ctrl <= 16'h0000;
                                busy_q <= 1'b1;
                            end
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // answer capture
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            rsp_q <= '0;
            rsp_new_q <= 1'b0;
        end else if (CLK_EN) begin
            if (MBOX.rsp_valid) begin
                rsp_q <= MBOX.rsp_msg;
                rsp_new_q <= 1'b1; // set wins over read clear
            end else if (RD && ADDR == `PCS_REG_RHDR) begin
                rsp_new_q <= 1'b0;
            end
        end
    end

    // read mux
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            rdata_q <= 32'h0;
        end else if (CLK_EN) begin
            rdata_q <= 32'h0;
            if (RD) begin
                case (ADDR)
                    `PCS_REG_HEADER: rdata_q <= {24'h0, req_q.hdr};
                    `PCS_REG_CTRL: rdata_q <= {16'h0, req_q.ctrl};
                    `PCS_REG_PARAM: rdata_q <= {24'h0, req_q.p0};
                    `PCS_REG_STAT: rdata_q <= {29'h0, refused_q, busy_q, rsp_new_q};
                    `PCS_REG_RHDR: rdata_q <= {24'h0, rsp_q.hdr};
                    `PCS_REG_RCTRL: rdata_q <= {16'h0, rsp_q.ctrl};
                    `PCS_REG_RP01: rdata_q <= {16'h0, rsp_q.p1, rsp_q.p0};
                    `PCS_REG_RP23: rdata_q <= {16'h0, rsp_q.p3, rsp_q.p2};
                    default: rdata_q <= 32'h0;
                endcase
            end
        end
    end

    assign RDATA = rdata_q;
    assign MBOX.req_valid = req_valid_q;
    assign MBOX.req_msg = req_q;
endmodule : pcs_host

// ===== pcs_asserts.sv
`timescale 1ns/1ps
`include "pcs_map.svh"
module pcs_asserts (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic NRST,
    // mailbox request
    input wire logic req_valid,
    input wire pcs_pkg::pcs_msg_t req_msg,
    // mailbox response
    input wire logic rsp_valid,
    input wire pcs_pkg::pcs_msg_t rsp_msg
);
    logic [1:0] req_path; // path field of request
    logic is_stat; // any status request
    logic stat_ok; // status request, legal path
    assign req_path = req_msg.hdr[7:6];
    assign is_stat = req_valid && req_msg.hdr[5:0] == `PCS_HDR_STATUS;
    assign stat_ok = is_stat && (req_path == `PCS_PATH_ONE || req_path == `PCS_PATH_TWO);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!NRST);
    a_status_answered: assert property (stat_ok |=> rsp_valid && rsp_msg.hdr[5:0] == `PCS_HDR_RESPONSE)
        else $error("no response to status request");
    a_path_echoed: assert property (stat_ok |=> rsp_msg.hdr[7:6] == $past(req_path))
        else $error("response path differs");
    a_bad_path_quiet: assert property (is_stat && !stat_ok |=> !rsp_valid)
        else $error("response to illegal path");
    a_rsp_has_cause: assert property (rsp_valid |-> $past(stat_ok))
        else $error("response without request");
    a_rsp_one_cycle: assert property (rsp_valid && !stat_ok |=> !rsp_valid)
        else $error("response valid too long");
    a_rsp_held: assert property (!rsp_valid |-> $stable(rsp_msg))
        else $error("response changed while idle");
    a_req_ctrl_zero: assert property (is_stat |-> req_msg.ctrl == 16'h0000)
        else $error("status request control not zero");
    a_ctrl_gap_zero: assert property (rsp_valid |-> rsp_msg.ctrl[13:11] == 3'h0)
        else $error("response control gap not zero");
    a_flags_data_only: assert property (rsp_valid && rsp_msg.ctrl[10:8] != 3'h2 |-> {rsp_msg.p2, rsp_msg.p3} == 16'h0000)
        else $error("flag bytes outside datamodem mode");
    a_flag_spares: assert property (rsp_valid |-> {rsp_msg.p2[7:6], rsp_msg.p2[3], rsp_msg.p3[7], rsp_msg.p3[3:2]} == 6'h00)
        else $error("spare flag bit set");
    a_phase_cause: assert property (rsp_valid && |{rsp_msg.p2[5:4], rsp_msg.p3[1:0]} |-> rsp_msg.p2[2])
        else $error("phase flag missing");
    a_timeout_tear: assert property (rsp_valid && rsp_msg.p3[4] |-> rsp_msg.p3[6])
        else $error("timeout without teardown");
endmodule : pcs_asserts

// ===== pump_command_status_messages_tb.sv
`timescale 1ns/1ps
`include "pcs_map.svh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; $display("unexpected %s: expected %h seen %h", nm, e, g); end end
module pump_command_status_messages_tb;
    // clock, reset, counters
    logic CORE_CLK = 1'b0;
    logic NRST = 1'b0;
    int mismatches = 0;
    int comparisons = 0;
    int cycles = 0;
    integer seed = 72174;
    // software port
    logic [3:0] ADDR = 4'h0;
    logic [31:0] WDATA = 32'h0;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic [31:0] RDATA;
    logic conv = 1'b1;
    logic clk_en = 1'b1;
    // pump state, events {rr,lr,rrn,lrn,done,first,norate,bulk,retry}
    logic [2:0] mode1 = 3'h0;
    logic [2:0] mode2 = 3'h0;
    logic [1:0] orig = 2'h0;
    logic [7:0] rate = 8'h00;
    logic [7:0] scheme = 8'h00;
    logic [8:0] ev = 9'h000;
    logic frame_ok = 1'b0;
    logic frame_bad = 1'b0;
    // device outputs
    logic tone_stb, tone_rej, sync, rx_en;
    logic [3:0] tone_dig;
    // expectation notes and scratch
    logic [31:0] rd_exp[$];
    logic [31:0] rd_mask[$];
    logic [5:0] tone_exp[$];
    logic rd_d = 1'b0;
    logic [31:0] e, m;
    logic [5:0] t;
    logic [2:0] md;
    logic [1:0] pt;
    logic [7:0] f2, f3;
    pcs_if mb();
    pcs_device pcs_device_i (.CORE_CLK(CORE_CLK), .NRST(NRST), .CLK_EN(clk_en), .MBOX(mb), .PATH1_MODE(mode1),
        .PATH2_MODE(mode2), .PATH1_ORIG(orig[0]), .PATH2_ORIG(orig[1]), .RATE_CODE(rate), .SCHEME_CODE(scheme),
        .REMOTE_RETRAIN(ev[8]), .LOCAL_RETRAIN(ev[7]), .REMOTE_RENEG(ev[6]), .LOCAL_RENEG(ev[5]),
        .TRAINING_DONE(ev[4]), .FIRST_TRAINING(ev[3]), .NO_RATE(ev[2]), .BULK_TIMEOUT(ev[1]), .RETRY_REQ(ev[0]),
        .FRAME_OK(frame_ok), .FRAME_BAD(frame_bad), .TONE_STROBE(tone_stb), .TONE_DIGIT(tone_dig),
        .TONE_REJECT(tone_rej), .V110_SYNC(sync), .RX_DATA_EN(rx_en));
    pcs_host pcs_host_i (.CORE_CLK(CORE_CLK), .NRST(NRST), .CLK_EN(clk_en), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
        .RD(RD), .RDATA(RDATA), .RATE_CONV_ON(conv), .MBOX(mb));
    pcs_asserts pcs_asserts_i (.CORE_CLK(CORE_CLK), .NRST(NRST), .req_valid(mb.req_valid), .req_msg(mb.req_msg),
        .rsp_valid(mb.rsp_valid), .rsp_msg(mb.rsp_msg));
    // clock and hang guard
    always #20 CORE_CLK = ~CORE_CLK;
    always @(posedge CORE_CLK) begin
        rd_d <= RD;
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            summarize();
        end
    end
    // watcher: oldest note against each read answer and tone event
    always @(negedge CORE_CLK) begin
        if (rd_d) begin
            e = rd_exp.pop_front();
            m = rd_mask.pop_front();
            `CHK("read data", e & m, RDATA & m)
        end
        if (tone_stb || tone_rej) begin
            t = tone_exp.pop_front();
            `CHK("tone event", t, {tone_stb, tone_rej, tone_stb ? tone_dig : 4'h0})
        end
    end
    // one register write, strobe for one cycle
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge CORE_CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CORE_CLK);
        WR <= 1'b0;
    endtask : wr
    // one register read, answer noted for the watcher
    task automatic rd(input logic [3:0] a, input logic [31:0] x, input logic [31:0] k);
        rd_exp.push_back(x);
        rd_mask.push_back(k);
        @(posedge CORE_CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CORE_CLK);
        RD <= 1'b0;
    endtask : rd
    // whole message through the host, then let it settle
    task automatic send(input logic [7:0] h, input logic [15:0] c, input logic [7:0] p);
        wr(`PCS_REG_HEADER, {24'h0, h});
        wr(`PCS_REG_CTRL, {16'h0, c});
        wr(`PCS_REG_PARAM, {24'h0, p});
        wr(`PCS_REG_GO, 32'h0);
        repeat (3) @(posedge CORE_CLK);
    endtask : send
    // one frame pulse, good or bad
    task automatic frame(input logic bad);
        @(posedge CORE_CLK);
        frame_ok <= ~bad;
        frame_bad <= bad;
        @(posedge CORE_CLK);
        frame_ok <= 1'b0;
        frame_bad <= 1'b0;
        repeat (2) @(negedge CORE_CLK);
    endtask : frame
    // verdict and end of run
    task automatic summarize;
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize
    // main sequence
    initial begin
        repeat (3) @(posedge CORE_CLK);
        NRST <= 1'b1;
        // status of every mode on both paths, random pump state
        for (int i = 0; i < 24; i++) begin
            md = (i < 16) ? 3'(i >> 1) : 3'h2;
            pt = i[0] ? `PCS_PATH_TWO : `PCS_PATH_ONE;
            @(posedge CORE_CLK);
            mode1 <= i[0] ? ~md : md;
            mode2 <= i[0] ? md : ~md;
            orig <= 2'($random(seed));
            rate <= 8'($random(seed));
            scheme <= 8'($random(seed));
            ev <= 9'($random(seed));
            @(posedge CORE_CLK);
            f2 = {2'b00, ev[8:7], 1'b0, |ev[8:5], ev[4] & ~ev[3], ev[3]};
            f3 = {1'b0, ev[2] | ev[1], ev[0] & ev[3], ev[1] & ev[3], 2'b00, ev[6:5]};
            send({pt, `PCS_HDR_STATUS}, 16'($random(seed)), 8'h00);
            rd(`PCS_REG_STAT, 32'h1, 32'h7);
            rd(`PCS_REG_CTRL, 32'h0, 32'hFFFF);
            rd(`PCS_REG_RHDR, {24'h0, pt, `PCS_HDR_RESPONSE}, 32'hFF);
            rd(`PCS_REG_RCTRL, {16'h0, orig[i[0]], 4'h0, md, 8'h00}, 32'hBF00);
            rd(`PCS_REG_RP01, {16'h0, scheme, rate}, 32'hFFFF);
            rd(`PCS_REG_RP23, {16'h0, (md == 3'h2) ? {f3, f2} : 16'h0}, 32'hFFFF);
            rd(`PCS_REG_STAT, 32'h0, 32'h3);
        end
        send({2'h0, `PCS_HDR_STATUS}, 16'h0, 8'h00);
        send({2'h3, `PCS_HDR_STATUS}, 16'h0, 8'h00);
        // every tone digit, then bad command, bad digits, wrong mode
        @(posedge CORE_CLK);
        mode1 <= 3'h6;
        for (int d = 16; d < 32; d++) begin
            tone_exp.push_back({2'b10, 4'(d)});
            send({`PCS_PATH_ONE, `PCS_HDR_CONTROL}, {`PCS_TONE_SEND, 8'h00}, 8'(d));
        end
        for (int b = 0; b < 4; b++) begin
            tone_exp.push_back(6'h10);
            if (b == 3) begin
                mode1 <= 3'h1;
            end
            send({`PCS_PATH_ONE, `PCS_HDR_CONTROL}, {(b == 0) ? 8'h5B : `PCS_TONE_SEND, 8'h00}, b[0] ? 8'h20 : 8'h0F);
        end
        // tone refused by the host without rate conversion
        mode1 <= 3'h6;
        conv <= 1'b0;
        send({`PCS_PATH_ONE, `PCS_HDR_CONTROL}, {`PCS_TONE_SEND, 8'h00}, 8'h13);
        rd(`PCS_REG_STAT, 32'h4, 32'h4);
        conv <= 1'b1;
        // frame sync: one frame by default, then four after extra count 3
        mode1 <= 3'h4;
        frame(1'b0);
        `CHK("sync default", 1'b1, sync)
        frame(1'b1);
        `CHK("sync lost", 1'b0, sync)
        tone_exp.push_back(6'h10);
        send({`PCS_PATH_ONE, `PCS_HDR_CONTROL}, 16'h5000, 8'h03);
        for (int k = 0; k < 4; k++) begin
            `CHK("sync early", 1'b0, rx_en)
            frame(1'b0);
        end
        `CHK("sync late", 2'h3, {sync, rx_en})
        // clock enable low freezes the frame logic
        @(posedge CORE_CLK);
        clk_en <= 1'b0;
        frame(1'b1);
        @(posedge CORE_CLK);
        clk_en <= 1'b1;
        @(negedge CORE_CLK);
        `CHK("sync frozen", 1'b1, sync)
        repeat (5) @(posedge CORE_CLK);
        `CHK("pending notes", 0, rd_exp.size() + tone_exp.size())
        summarize();
    end
endmodule : pump_command_status_messages_tb
